// ### pkg/arf_consts.svh
/*
 Register offsets, field positions, reset values and widths for the
 upper-node asynchronous request filter.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH

`define ARF_ADDR_W          12
`define ARF_OFS_FILT_SET    12'h100
`define ARF_OFS_FILT_CLR    12'h104
`define ARF_OFS_OWN_BUS     12'h110
`define ARF_OFS_STATUS      12'h114

`define ARF_FILT_RESET      32'h0000_0000
`define ARF_ALL_BUS_BIT     5
`define ARF_ALL_BUS_POS     31
`define ARF_NODE_BASE       6'h20
`define ARF_NODE_NONE       6'h3f

`define ARF_BUS_LSB         6
`define ARF_BUS_MSB         15
`define ARF_BUS_RESET       10'h3ff

`define ARF_CNT_W           16
`define ARF_CNT_MAX         16'hffff

`define ARF_RESP_OKAY       2'b00
`define ARF_RESP_SLVERR     2'b10

`endif

// ### pkg/arf_pkg.sv
/*
 Types shared by the upper-node asynchronous request filter.
 Assumes arf_consts.svh is on the include path.
*/
`include "arf_consts.svh"

package arf_pkg;

    typedef enum logic [1:0] {
        ARF_CTX_OTHER    = 2'b00,
        ARF_CTX_PHYS_REQ = 2'b01,
        ARF_CTX_ASYNC_RQ = 2'b10
    } arf_ctx_t;

    // One incoming request header, as decoded by the receive path
    typedef struct packed {
        logic     valid;
        arf_ctx_t ctx;
        logic [9:0] src_bus;
        logic [5:0] src_node;
    } arf_pkt_t;

    // Verdict for the receive path, one cycle after the header
    typedef struct packed {
        logic valid;
        logic checked;
        logic in_range;
        logic ack;
        logic enqueue;
    } arf_verdict_t;

endpackage

// ### hdl/arf_filter.sv
/*
 Upper-node asynchronous request filter with its AXI4-Lite register slave.
 Assumes a receive path on ref_clk that presents one header per cycle
 and honours the verdict returned one cycle later.
*/
// What this block does
// RQ1: One enable bit per upper node permits or blocks its requests.
// RQ2: Headers for physical-request or async-request contexts are checked.
// RQ3: Clear bit for the source node means no ack and no enqueue.
// RQ4: Per-node comparison applies only to sources on our own bus.
// RQ5: Remote-bus requests rejected unless bit 31 is set, then all accepted.
// RQ6: Node 62 maps to bit 30, descending one bit per node to bit 0.
// RQ7: Filter reached through a set offset and a clear offset.
// RQ8: Ones set or clear bits, zeros ignored, reads return filter, reset zero.
// RQ9: Locality decided by comparing source bus with own programmable bus id.
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"

module arf_filter
(
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [31:0]           s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire arf_pkg::arf_pkt_t     pkt_in,
    output var  arf_pkg::arf_verdict_t verdict_out
);
    import arf_pkg::*;

    logic [31:0]          filt_q;
    logic [9:0]           own_bus_q;
    logic [`ARF_CNT_W-1:0] rej_cnt_q;
    logic                 aw_h_q;
    logic                 w_h_q;
    logic [11:0]          awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 wr_fire;
    logic [31:0]          wmask;
    logic [31:0]          filt_d;
    logic                 wr_set;
    logic                 wr_clr;
    logic                 wr_own;
    arf_verdict_t         verdict_d;

    // Byte enables widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    // Word-aligned decode, shared by read and write paths
    function automatic logic is_mapped(input logic [11:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        return (w == `ARF_OFS_FILT_SET) || (w == `ARF_OFS_FILT_CLR)
            || (w == `ARF_OFS_OWN_BUS) || (w == `ARF_OFS_STATUS);
    endfunction

    // Bits 1:0 dropped; every register is one aligned word
    function automatic logic [11:0] word_addr(input logic [11:0] a);
        return {a[11:2], 2'b00};
    endfunction

    assign wr_fire = aw_h_q && w_h_q && !s_axi_bvalid;
    assign wmask   = wdata_q & strb_mask(wstrb_q);

    // Readies stay low while a response waits: one write in flight
    assign wr_set  = wr_fire && (word_addr(awaddr_q) == `ARF_OFS_FILT_SET);
    assign wr_clr  = wr_fire && (word_addr(awaddr_q) == `ARF_OFS_FILT_CLR);
    assign wr_own  = wr_fire && (word_addr(awaddr_q) == `ARF_OFS_OWN_BUS);

    // Write address channel; either channel may arrive first
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_h_q        <= 1'b0;
            awaddr_q      <= 12'h000;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_h_q        <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (wr_fire)
        begin
            aw_h_q <= 1'b0;
        end
        else if (!aw_h_q && !s_axi_bvalid)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            w_h_q        <= 1'b0;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_h_q        <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (wr_fire)
        begin
            w_h_q <= 1'b0;
        end
        else if (!w_h_q && !s_axi_bvalid)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response, one cycle after both halves are held
    // Unmapped offsets answer SLVERR and change nothing
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ARF_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(awaddr_q) ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Filter bits: set and clear offsets, ones act, zeros ignored
    // One cell per bit; only the addressed offset touches it
    for (genvar g = 0; g < 32; g++)
    begin : g_filt
        assign filt_d[g] = (wr_set && wmask[g]) ? 1'b1
                         : (wr_clr && wmask[g]) ? 1'b0
                         : filt_q[g]; // see RQ7 see RQ8
    end

    // Filter register, takes the per-bit next value each edge
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            filt_q <= `ARF_FILT_RESET; // see RQ8
        end
        else
        begin
            filt_q <= filt_d; // see RQ1
        end
    end

    // Own bus id, bits 15:6 of its word; lanes honoured per byte
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            own_bus_q <= `ARF_BUS_RESET;
        end
        else if (wr_own)
        begin
            if (wstrb_q[0])
            begin
                own_bus_q[1:0] <= wdata_q[7:6];
            end
            if (wstrb_q[1])
            begin
                own_bus_q[9:2] <= wdata_q[`ARF_BUS_MSB:8];
            end
        end
    end

    // Read channel; a single read in flight at a time
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ARF_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
            // Both filter offsets read back the same word
            case (word_addr(s_axi_araddr))
                `ARF_OFS_FILT_SET: s_axi_rdata <= filt_q; // see RQ8
                `ARF_OFS_FILT_CLR: s_axi_rdata <= filt_q; // see RQ8
                `ARF_OFS_OWN_BUS:  s_axi_rdata <= {16'h0000, own_bus_q, 6'h00};
                `ARF_OFS_STATUS:   s_axi_rdata <= {16'h0000, rej_cnt_q};
                default:           s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
        else if (!s_axi_rvalid)
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // Verdict; own-bus nodes below 32 belong to the low filter, so get in_range and ack low
    always_comb
    begin
        logic       local_src;
        logic [5:0] idx;
        local_src = (pkt_in.src_bus == own_bus_q); // see RQ9
        idx       = pkt_in.src_node - `ARF_NODE_BASE; // see RQ6
        verdict_d          = '0;
        verdict_d.valid    = pkt_in.valid;
        verdict_d.checked  = pkt_in.valid && (pkt_in.ctx == ARF_CTX_PHYS_REQ
                             || pkt_in.ctx == ARF_CTX_ASYNC_RQ); // see RQ2
        verdict_d.in_range = 1'b1;
        verdict_d.ack      = 1'b1;
        if (verdict_d.checked)
        begin
            if (!local_src)
            begin
                verdict_d.ack = filt_q[`ARF_ALL_BUS_POS]; // see RQ5
            end
            else if (pkt_in.src_node[5] && pkt_in.src_node != `ARF_NODE_NONE)
            begin
                verdict_d.ack = filt_q[idx[4:0]]; // see RQ1 see RQ4 see RQ6
            end
            else
            begin
                verdict_d.in_range = 1'b0;
                verdict_d.ack      = 1'b0;
            end
        end
        verdict_d.enqueue = verdict_d.valid && verdict_d.ack; // see RQ3
        verdict_d.ack     = verdict_d.valid && verdict_d.ack;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            verdict_out <= '0;
        end
        else
        begin
            verdict_out <= verdict_d; // see RQ3
        end
    end

    // Saturating count of rejected in-range requests, for software visibility
    // Saturates so software never reads a wrapped, falsely small count
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rej_cnt_q <= '0;
        end
        else if (verdict_d.checked && verdict_d.in_range && !verdict_d.ack
                 && rej_cnt_q != `ARF_CNT_MAX)
        begin
            rej_cnt_q <= rej_cnt_q + 16'h0001;
        end
    end

endmodule
`default_nettype wire

// ### testbench/arf_node_src.sv
/* Remote node model sending request headers to the filter.
   Assumes the caller starts a send just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module arf_node_src
(
    input  wire logic              ref_clk,
    output var  arf_pkg::arf_pkt_t pkt_in
);
    import arf_pkg::*;
    initial pkt_in = '0;
    // One header per call; inverted fields after, so no stale match
    task automatic send(input arf_ctx_t c, input logic [9:0] b, input logic [5:0] n);
        pkt_in <= '{1'b1, c, b, n};
        @(posedge ref_clk);
        pkt_in <= '{1'b0, c, ~b, ~n};
    endtask
endmodule
`default_nettype wire

// ### testbench/arf_filter_asserts.sv
/* Port assertions for the request filter.
   Bound to every arf_filter instance by port name. */
`timescale 1ns/1ps
`default_nettype none
module arf_filter_asserts
(
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire arf_pkg::arf_pkt_t     pkt_in,
    input wire arf_pkg::arf_verdict_t verdict_out
);
    import arf_pkg::*;
    logic wr_seen_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Conservative: any write address counts, even unmapped
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst) wr_seen_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready) wr_seen_q <= 1'b1;
    vld_follow_a: assert property (1'b1 |=> verdict_out.valid == $past(pkt_in.valid))
        else $error("verdict valid does not follow header");
    other_pass_a: assert property (pkt_in.valid && pkt_in.ctx == ARF_CTX_OTHER
        |=> verdict_out.ack && verdict_out.enqueue && !verdict_out.checked) else $error("bad pass");
    ctx_checked_a: assert property (pkt_in.valid && pkt_in.ctx != ARF_CTX_OTHER
        |=> verdict_out.checked) else $error("request context not checked");
    ack_enq_a: assert property (verdict_out.valid |-> verdict_out.ack == verdict_out.enqueue)
        else $error("ack and enqueue differ");
    idle_quiet_a: assert property (!verdict_out.valid |-> !verdict_out.ack && !verdict_out.enqueue)
        else $error("ack without header");
    reset_block_a: assert property (!wr_seen_q && pkt_in.valid && pkt_in.ctx != ARF_CTX_OTHER
        |=> !verdict_out.ack) else $error("ack with cleared filter");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    wr_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    cover property (verdict_out.checked && verdict_out.ack);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property (verdict_out.valid && !verdict_out.ack);
endmodule
bind arf_filter arf_filter_asserts u_chk
(
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .pkt_in        (pkt_in),
    .verdict_out   (verdict_out)
);
`default_nettype wire

// ### testbench/tb_arf_filter.sv
/* Self-checking bench for the request filter.
   Assumes the package, header and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
module tb_arf_filter;
    import arf_pkg::*;
    logic ref_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, filt, d;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] own;
    arf_pkt_t pkt_in;
    arf_verdict_t verdict_out;
    int bad_count = 0, n_tests = 0, seed = 27, rej = 0;
    arf_filter u_dut (.*);
    arf_node_src u_src (.*);
    always #2 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 40)
        begin
            bad_count++;
            $display("[ERR] %0t bus timeout", $time);
            final_report;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        tmo(n);
        chk(32'(s_axi_bresp), 32'(r));
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'b0;
        tmo(n);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(r));
        @(posedge ref_clk);
    endtask
    // {valid, checked, in_range, ack, enqueue}
    function automatic logic [4:0] exp_v(arf_ctx_t c, logic [9:0] b, logic [5:0] n);
        if (c == ARF_CTX_OTHER) return 5'b10111;
        if (b != own) return {3'b111, {2{filt[31]}}};
        if (n >= 6'd32 && n != 6'd63) return {3'b111, {2{filt[n - 6'd32]}}};
        return 5'b11000;
    endfunction
    task automatic pk(input arf_ctx_t c, input logic [9:0] b, input logic [5:0] n);
        logic [4:0] e;
        e = exp_v(c, b, n);
        u_src.send(c, b, n);
        #1;
        chk({27'h0, verdict_out}, {27'h0, e});
        if (e[3] && e[2] && !e[1]) rej++;
        @(posedge ref_clk);
    endtask
    initial
    begin
        #400000;
        bad_count++;
        final_report;
    end
    initial
    begin
        filt = '0;
        own = 10'h3ff;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        pk(ARF_CTX_ASYNC_RQ, own, 6'd62);
        pk(ARF_CTX_PHYS_REQ, 10'h001, 6'd40);
        rd(`ARF_OFS_FILT_SET, 32'h0, `ARF_RESP_OKAY);
        rd(`ARF_OFS_OWN_BUS, 32'h0000_ffc0, `ARF_RESP_OKAY);
        rd(12'h200, 32'h0, `ARF_RESP_SLVERR);
        wr(12'h200, 32'hffff_ffff, `ARF_RESP_SLVERR);
        filt = 32'h4008_0001;
        wr(`ARF_OFS_FILT_SET, filt, `ARF_RESP_OKAY);
        // Node to bit corners, 63 has no bit
        pk(ARF_CTX_ASYNC_RQ, own, 6'd62);
        pk(ARF_CTX_ASYNC_RQ, own, 6'd51);
        pk(ARF_CTX_PHYS_REQ, own, 6'd32);
        pk(ARF_CTX_ASYNC_RQ, own, 6'd61);
        pk(ARF_CTX_PHYS_REQ, own, 6'd63);
        filt[31] = 1'b1;
        wr(`ARF_OFS_FILT_SET, 32'h8000_0000, `ARF_RESP_OKAY);
        pk(ARF_CTX_PHYS_REQ, 10'h001, 6'd5);
        own = 10'($random(seed));
        wr(`ARF_OFS_OWN_BUS, {16'h0, own, 6'h0}, `ARF_RESP_OKAY);
        pk(ARF_CTX_ASYNC_RQ, ~own, 6'd62);
        repeat (60)
        begin
            d = $random(seed);
            if (d[0])
                filt = filt | d;
            else
                filt = filt & ~d;
            wr(d[0] ? `ARF_OFS_FILT_SET : `ARF_OFS_FILT_CLR, d, `ARF_RESP_OKAY);
            rd(`ARF_OFS_FILT_CLR, filt, `ARF_RESP_OKAY);
            d = $random(seed);
            pk(d[1:0] == 2'b11 ? ARF_CTX_ASYNC_RQ : arf_ctx_t'(d[1:0]),
               d[2] ? own : d[12:3], d[18:13]);
        end
        rd(`ARF_OFS_STATUS, 32'(rej), `ARF_RESP_OKAY);
        final_report;
    end
endmodule
`default_nettype wire
